//--- include/twu_pkg.sv
// Shared constants and types for the timer/watchdog unit.
// Assumes a single 50 MHz clock domain with a synchronous reset.
package twu_pkg;
   // Internal clock division for the timer time base.
   localparam int DIV_INT = 4;
   localparam logic [1:0] DIV_LAST = 2'(DIV_INT - 1);
   // Reset values of the software-visible registers.
   localparam logic [7:0] CTRL_RESET = 8'h12;
   localparam logic [7:0] PRESC_RESET = 8'hFF;
   localparam logic [15:0] COUNT_RESET = 16'hFFFF;
   // Fixed time base while the watchdog is hardware enabled.
   localparam logic [15:0] WD_HW_CONST = 16'hFFFF;
   // Watchdog service key values, written in this order.
   localparam logic [7:0] WD_KEY_FIRST = 8'hAA;
   localparam logic [7:0] WD_KEY_SECOND = 8'h55;
   // Bit positions in the timer control register.
   localparam int CTL_RUN = 7;
   localparam int CTL_SINGLE = 6;
   localparam int CTL_MODE_HI = 5;
   localparam int CTL_MODE_LO = 4;
   localparam int CTL_IN_EN = 3;
   localparam int CTL_OUT_MODE = 2;
   localparam int CTL_OUT_VAL = 1;
   localparam int CTL_OUT_EN = 0;
   // Input section modes.
   typedef enum logic [1:0] {
      TWU_IN_EVENT = 2'h0,
      TWU_IN_GATED = 2'h1,
      TWU_IN_TRIG = 2'h2,
      TWU_IN_RETRIG = 2'h3
   } twu_inmode_t;
   // Counting state of the input section.
   typedef enum logic [2:0] {
      TWU_ST_STOP = 3'h1,
      TWU_ST_WAIT = 3'h2,
      TWU_ST_COUNT = 3'h4
   } twu_state_t;
endpackage

//--- include/twu_presc_if.sv
// Link between the timer core and its prescaler.
// Assumes both ends share one clock; carries no clock itself.
`timescale 1ns/1ps
`default_nettype none
interface twu_presc_if;
   logic tick;
   logic clear;
   logic [7:0] div_value;
   logic carry;
   modport ctrl (output tick, output clear, output div_value, input carry);
   modport presc (input tick, input clear, input div_value, output carry);
endinterface
`default_nettype wire

//--- hw/twu_presc.sv
// Eight-bit prescaler: one carry per div_value+1 input ticks.
// Assumes ticks arrive as single-cycle enables on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module twu_presc (
   input wire logic ref_clk,
   input wire logic srst,
   twu_presc_if.presc pif
);
   logic [7:0] pdiv_reg;

   // A lowered divisor takes effect at once, so compare with at-or-above.
   assign pif.carry = pif.tick && (pdiv_reg >= pif.div_value);

   // Count ticks and wrap on carry.
   always_ff @(posedge ref_clk) begin
      if (srst || pif.clear) begin
         pdiv_reg <= 8'h00;
      end else if (pif.tick) begin
         pdiv_reg <= pif.carry ? 8'h00 : 8'(pdiv_reg + 8'h01);
      end
   end

   // A divisor of zero passes every tick through.
   div_one_a: assert property (@(posedge ref_clk) disable iff (srst)
      (pif.tick && pif.div_value == 8'h00) |-> pif.carry)
      else $error("Prescaler failed to pass a tick at divisor one.");
endmodule
`default_nettype wire

//--- hw/twu_top.sv
// Timer/watchdog unit: 16-bit down counter with 8-bit prescaler.
// Assumes all inputs are synchronous to ref_clk; write strobes last one cycle.
// How it works
// - Sixteen-bit down counter behind eight-bit prescaler.
// - Clock from input pin or clock/4.
// - Run bit starts next cycle; clear stops.
// - Restart resumes held count unless rewritten.
// - Running constant waits EOC; prescaler immediate.
// - End of count when counter is zero.
// - Watchdog mode ignores the run bit.
// - Single/continuous bit writable anytime, with run.
// - Single mode EOC stops, reloads, clears run.
// - Constant changed while stopped loads at restart.
// - Continuous mode reloads and keeps counting.
// - Input enable selects pin or clock/4.
// - Event mode counts each falling input edge.
// - Event counting starts first edge after run.
// - Gated mode counts clock/4 while pin high.
// - Triggerable mode starts on edge after run.
// - Retriggerable edge reloads; ignored while stopped.
// - Output disabled drives pin high.
// - Square mode toggles output each EOC.
// - PWM mode copies value bit at EOC.
// - EOC interrupt routes to top level or A0.
// - Watchdog resets system unless serviced in time.
// - Keys AAh then 55h to low reload.
// - Watchdog end of count requests system reset.
// - Prescaler divides by value plus one.
// - Select pin low enables watchdog, fixed FFFFh.
`timescale 1ns/1ps
`default_nettype none
module twu_top (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [7:0] wdata,
   input wire logic count_low_wr,
   input wire logic count_high_wr,
   input wire logic prescale_wr,
   input wire logic control_wr,
   input wire logic watchdog_enable_wr,
   input wire logic watchdog_enable_bit,
   input wire logic ia0_select,
   input wire logic top_level_select,
   input wire logic timer_input_pin,
   input wire logic ext_irq_input,
   input wire logic hard_soft_watchdog_select,
   output logic [7:0] timer_control_reg,
   output logic [15:0] count_reg,
   output logic [7:0] prescale_reg,
   output logic watchdog_active_reg,
   output logic timer_output_pin,
   output logic irq_a0_reg,
   output logic irq_top_level_reg,
   output logic system_reset_reg
);
   twu_presc_if pif ();
   logic [1:0] div_reg;
   logic div_tick;
   logic pin_prev_reg;
   logic pin_fall;
   logic [15:0] const_reg;
   logic const_dirty_reg;
   logic key_seen_reg;
   logic out_level_reg;
   twu_pkg::twu_state_t state_reg;
   twu_pkg::twu_state_t state_next;
   twu_pkg::twu_inmode_t in_mode;
   logic run_w;
   logic ext_sel;
   logic count_tick;
   logic retrig_hit;
   logic wd_reload;
   logic start_load;
   logic eoc;
   logic timer_irq;

   // Returns true for the input modes that wait for a first falling edge.
   function automatic logic waits_edge(input twu_pkg::twu_inmode_t m);
      waits_edge = (m == twu_pkg::TWU_IN_EVENT) || (m == twu_pkg::TWU_IN_TRIG);
   endfunction

   twu_presc u_presc (
      .ref_clk(ref_clk),
      .srst(srst),
      .pif(pif.presc)
   );

   // Free-running divide-by-four of the internal clock.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= 2'(div_reg + 2'h1);
      end
   end
   assign div_tick = (div_reg == twu_pkg::DIV_LAST);

   // Previous pin level for falling edge detection.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pin_prev_reg <= 1'b1;
      end else begin
         pin_prev_reg <= timer_input_pin;
      end
   end
   assign pin_fall = pin_prev_reg && !timer_input_pin;

   // Mode decode; the watchdog forces continuous internal counting.
   assign in_mode = twu_pkg::twu_inmode_t'(timer_control_reg[twu_pkg::CTL_MODE_HI:
                                                             twu_pkg::CTL_MODE_LO]);
   assign run_w = watchdog_active_reg || timer_control_reg[twu_pkg::CTL_RUN];
   assign ext_sel = timer_control_reg[twu_pkg::CTL_IN_EN] && !watchdog_active_reg;

   // Input section state: stopped, waiting for the first edge, or counting.
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         twu_pkg::TWU_ST_STOP: begin
            if (run_w) begin
               state_next = (ext_sel && waits_edge(in_mode)) ?
                  twu_pkg::TWU_ST_WAIT : twu_pkg::TWU_ST_COUNT;
            end
         end
         twu_pkg::TWU_ST_WAIT: begin
            if (!run_w) begin
               state_next = twu_pkg::TWU_ST_STOP;
            end else if (pin_fall) begin
               state_next = twu_pkg::TWU_ST_COUNT;
            end
         end
         twu_pkg::TWU_ST_COUNT: begin
            if (!run_w) begin
               state_next = twu_pkg::TWU_ST_STOP;
            end
         end
         default: state_next = twu_pkg::TWU_ST_STOP;
      endcase
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_reg <= twu_pkg::TWU_ST_STOP;
      end else begin
         state_reg <= state_next;
      end
   end

   // Prescaler input tick from the selected time base.
   always_comb begin
      count_tick = 1'b0;
      if (state_reg == twu_pkg::TWU_ST_COUNT && run_w) begin
         if (!ext_sel) begin
            count_tick = div_tick;
         end else begin
            unique case (in_mode)
               twu_pkg::TWU_IN_EVENT: count_tick = pin_fall;
               twu_pkg::TWU_IN_GATED: count_tick = div_tick && timer_input_pin;
               twu_pkg::TWU_IN_TRIG: count_tick = div_tick;
               twu_pkg::TWU_IN_RETRIG: count_tick = div_tick;
            endcase
         end
      end
   end

   // Retrigger edges only act while counting; the watchdog key reloads too.
   assign retrig_hit = ext_sel && in_mode == twu_pkg::TWU_IN_RETRIG &&
                       state_reg == twu_pkg::TWU_ST_COUNT && run_w && pin_fall;
   assign wd_reload = watchdog_active_reg && count_low_wr &&
                      wdata == twu_pkg::WD_KEY_SECOND && key_seen_reg;
   assign start_load = state_reg == twu_pkg::TWU_ST_STOP && run_w && const_dirty_reg;
   assign eoc = pif.carry && count_reg == 16'h0000;
   assign timer_irq = eoc && !watchdog_active_reg;

   // Prescaler hookup; its divisor is live so writes act immediately.
   assign pif.tick = count_tick;
   assign pif.clear = retrig_hit || wd_reload;
   assign pif.div_value = prescale_reg;

   // Prescaler register, writable even in watchdog mode.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prescale_reg <= twu_pkg::PRESC_RESET;
      end else if (prescale_wr) begin
         prescale_reg <= wdata;
      end
   end

   // Reload constant; frozen in watchdog mode, so the hardware base stays FFFFh.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         const_reg <= twu_pkg::WD_HW_CONST;
      end else if (!watchdog_active_reg) begin
         if (count_low_wr) begin
            const_reg[7:0] <= wdata;
         end
         if (count_high_wr) begin
            const_reg[15:8] <= wdata;
         end
      end
   end

   // Marks a constant written since the last load; a write beats a load.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         const_dirty_reg <= 1'b0;
      end else if (!watchdog_active_reg && (count_low_wr || count_high_wr)) begin
         const_dirty_reg <= 1'b1;
      end else if (eoc || start_load) begin
         const_dirty_reg <= 1'b0;
      end
   end

   // Down counter with its reload sources.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         count_reg <= twu_pkg::COUNT_RESET;
      end else if (wd_reload || retrig_hit || start_load) begin
         count_reg <= const_reg;
      end else if (pif.carry) begin
         count_reg <= eoc ? const_reg : 16'(count_reg - 16'h0001);
      end
   end

   // Control register; a software write wins over the single-mode clear.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer_control_reg <= twu_pkg::CTRL_RESET;
      end else if (control_wr) begin
         timer_control_reg <= wdata;
      end else if (eoc && timer_control_reg[twu_pkg::CTL_SINGLE] && !watchdog_active_reg) begin
         timer_control_reg[twu_pkg::CTL_RUN] <= 1'b0;
      end
   end

   // Watchdog enable: strap caught at reset, or software clears the enable bit.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         watchdog_active_reg <= !hard_soft_watchdog_select;
      end else if (watchdog_enable_wr && !watchdog_enable_bit) begin
         watchdog_active_reg <= 1'b1;
      end
   end

   // Service key tracker: any low write other than the key breaks the pair.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         key_seen_reg <= 1'b0;
      end else if (watchdog_active_reg && count_low_wr) begin
         key_seen_reg <= (wdata == twu_pkg::WD_KEY_FIRST);
      end
   end

   // System reset request on watchdog timeout.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         system_reset_reg <= 1'b0;
      end else begin
         system_reset_reg <= eoc && watchdog_active_reg;
      end
   end

   // Output waveform level, updated at each end of count.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_level_reg <= 1'b1;
      end else if (eoc) begin
         if (timer_control_reg[twu_pkg::CTL_OUT_MODE]) begin
            out_level_reg <= timer_control_reg[twu_pkg::CTL_OUT_VAL];
         end else begin
            out_level_reg <= !out_level_reg;
         end
      end
   end

   // Output pin: high while disabled so other functions can share it.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         timer_output_pin <= 1'b1;
      end else begin
         timer_output_pin <= !timer_control_reg[twu_pkg::CTL_OUT_EN] || out_level_reg;
      end
   end

   // Interrupt routing; with both selects low only channel A0 sees the timer.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         irq_a0_reg <= 1'b0;
         irq_top_level_reg <= 1'b0;
      end else begin
         irq_a0_reg <= ia0_select ? ext_irq_input : timer_irq;
         irq_top_level_reg <= top_level_select ? ext_irq_input :
                              (ia0_select && timer_irq);
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);

   sequence key_first_s;
      watchdog_active_reg && count_low_wr && wdata == twu_pkg::WD_KEY_FIRST;
   endsequence
   sequence key_second_s;
      watchdog_active_reg && count_low_wr && wdata == twu_pkg::WD_KEY_SECOND;
   endsequence

   div_period_a: assert property (div_tick |=> !div_tick [*3] ##1 div_tick)
      else $error("Divided clock tick not every fourth cycle.");
   eoc_reload_a: assert property (eoc && !wd_reload && !retrig_hit |=>
      count_reg == $past(const_reg))
      else $error("End of count did not reload the constant.");
   count_step_a: assert property (pif.carry && count_reg != 16'h0000 && !pif.clear &&
      !start_load |=> count_reg == 16'($past(count_reg) - 16'h0001))
      else $error("Counter did not decrement on prescaler carry.");
   single_stop_a: assert property (eoc && timer_control_reg[twu_pkg::CTL_SINGLE] &&
      !watchdog_active_reg && !control_wr |=> !timer_control_reg[twu_pkg::CTL_RUN])
      else $error("Single mode did not clear the run bit.");
   stopped_hold_a: assert property (state_reg == twu_pkg::TWU_ST_STOP && !run_w &&
      !control_wr && !watchdog_enable_wr |=> $stable(count_reg) [*2])
      else $error("Count moved while stopped.");
   wd_service_a: assert property (key_first_s ##1 key_second_s |=>
      count_reg == const_reg)
      else $error("Watchdog key pair did not reload the counter.");
   wd_gap_a: assert property (key_first_s ##1 !count_low_wr ##1 key_second_s |=>
      count_reg == const_reg)
      else $error("Spaced watchdog key pair did not reload the counter.");
   wd_reset_a: assert property (eoc && watchdog_active_reg |=> system_reset_reg)
      else $error("Watchdog timeout gave no reset request.");
   out_off_a: assert property (!timer_control_reg[twu_pkg::CTL_OUT_EN] |=>
      timer_output_pin)
      else $error("Disabled output not driven high.");
   square_a: assert property (eoc && !timer_control_reg[twu_pkg::CTL_OUT_MODE] |=>
      out_level_reg != $past(out_level_reg))
      else $error("Square wave did not toggle at end of count.");
   retrig_a: assert property (retrig_hit |=> count_reg == $past(const_reg))
      else $error("Retrigger edge did not restart the count.");
   wd_runs_a: assert property (watchdog_active_reg |-> ##[0:2]
      state_reg == twu_pkg::TWU_ST_COUNT)
      else $error("Watchdog mode is not counting.");
endmodule
`default_nettype wire

//--- sim/twu_pin_partner.sv
// Far-side model for the timer unit: the source that drives the timer input pin.
// Assumes the bench calls its tasks from the falling edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module twu_pin_partner (
   input wire logic ref_clk,
   output logic timer_input_pin
);
   // The input idles high, so the first low level is a real falling edge.
   initial begin
      timer_input_pin = 1'b1;
   end

   // Drives one falling edge; low holds 5 cycles, high 6 until the next call, so edges sit 11 cycles apart.
   task automatic fall();
      @(negedge ref_clk);
      timer_input_pin = 1'b0;
      repeat (5) @(negedge ref_clk);
      timer_input_pin = 1'b1;
      repeat (5) @(negedge ref_clk);
   endtask

   // Sets a steady level, as a gate signal does.
   task automatic level(input logic v);
      @(negedge ref_clk);
      timer_input_pin = v;
   endtask
endmodule
`default_nettype wire

//--- sim/twu_tb_top.sv
// Self-checking bench for the timer/watchdog unit, driven through its write strobes.
// Assumes twu_pkg and the design files are compiled first; inputs change at the falling edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module twu_tb_top;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] wdata = 8'h00;
   logic [4:0] wr_v = 5'h00;
   logic wd_bit = 1'b1;
   logic ia0_sel = 1'b0;
   logic top_sel = 1'b0;
   logic ext_irq = 1'b0;
   logic strap = 1'b1;
   wire logic timer_input_pin;
   logic [7:0] timer_control_reg;
   logic [15:0] count_reg;
   logic [7:0] prescale_reg;
   logic watchdog_active_reg, timer_output_pin, irq_a0_reg, irq_top_level_reg, system_reset_reg;
   int n_mismatch = 0;
   int num_checks = 0;
   int irq_cnt = 0;
   int rst_cnt = 0;
   int n, c0;
   logic p1;
   logic [15:0] held;

   // The 50 MHz clock.
   always #10 ref_clk = ~ref_clk;

   twu_top u_twu_top (.ref_clk(ref_clk), .srst(srst), .wdata(wdata),
      .count_low_wr(wr_v[0]), .count_high_wr(wr_v[1]), .prescale_wr(wr_v[2]),
      .control_wr(wr_v[3]), .watchdog_enable_wr(wr_v[4]), .watchdog_enable_bit(wd_bit),
      .ia0_select(ia0_sel), .top_level_select(top_sel), .timer_input_pin(timer_input_pin),
      .ext_irq_input(ext_irq), .hard_soft_watchdog_select(strap),
      .timer_control_reg(timer_control_reg), .count_reg(count_reg),
      .prescale_reg(prescale_reg), .watchdog_active_reg(watchdog_active_reg),
      .timer_output_pin(timer_output_pin), .irq_a0_reg(irq_a0_reg),
      .irq_top_level_reg(irq_top_level_reg), .system_reset_reg(system_reset_reg));

   twu_pin_partner u_twu_pin_partner (.ref_clk(ref_clk), .timer_input_pin(timer_input_pin));

   // Counts one-cycle pulses so that none is missed while a task is busy.
   always @(posedge ref_clk) begin
      if (irq_a0_reg === 1'b1) irq_cnt++;
      if (system_reset_reg === 1'b1) rst_cnt++;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // One write: strobe sel (0 low, 1 high, 2 prescaler, 3 control, 4 watchdog) for a cycle.
   task automatic wr(input int sel, input logic [7:0] d);
      @(negedge ref_clk);
      wr_v[sel] = 1'b1;
      wdata = d;
      @(negedge ref_clk);
      wr_v = 5'h00;
   endtask

   // Holds reset for 20 cycles with the given watchdog strap.
   task automatic do_reset(input logic s);
      @(negedge ref_clk);
      srst = 1'b1;
      strap = s;
      repeat (20) @(negedge ref_clk);
      srst = 1'b0;
   endtask

   // Waits for a pulse (0 channel A0, 1 top level, 2 system reset); n is the cycle count.
   task automatic wait_evt(input int which, output int cyc);
      logic s;
      cyc = 0;
      do begin
         @(negedge ref_clk);
         cyc++;
         s = (which == 0) ? irq_a0_reg : (which == 1) ? irq_top_level_reg : system_reset_reg;
      end while (s !== 1'b1 && cyc < 3000);
      `CHK(s, 1'b1)
   endtask

   // Stops the timer, sets a new low constant byte, then writes the control value.
   task automatic arm(input logic [7:0] lo, input logic [7:0] ctl);
      wr(3, 8'h00);
      wr(0, lo);
      wr(3, ctl);
   endtask

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      tally_and_finish();
   end

   initial begin
      do_reset(1'b1);
      @(negedge ref_clk);
      `CHK(timer_control_reg, 8'h12)
      `CHK(count_reg, 16'hFFFF)
      `CHK(prescale_reg, 8'hFF)
      `CHK(timer_output_pin, 1'b1)
      `CHK(watchdog_active_reg, 1'b0)
      // Continuous internal count: constant 3, prescaler 1 gives 4*2*4 cycles per end.
      wr(0, 8'h03);
      wr(1, 8'h00);
      wr(2, 8'h01);
      wr(3, 8'h81);
      wait_evt(0, n);
      wait_evt(0, n);
      `CHK(n, 32)
      p1 = timer_output_pin;
      wait_evt(0, n);
      `CHK(n, 32)
      `CHK(timer_output_pin, ~p1)
      // A constant written while running waits for the next end of count.
      wr(0, 8'h07);
      wait_evt(0, n);
      wait_evt(0, n);
      `CHK(n, 64)
      // Value bit reaches the pin at each end of count.
      wr(3, 8'h87);
      wait_evt(0, n);
      repeat (2) @(negedge ref_clk);
      `CHK(timer_output_pin, 1'b1)
      wr(3, 8'h85);
      wait_evt(0, n);
      repeat (2) @(negedge ref_clk);
      `CHK(timer_output_pin, 1'b0)
      // Channel A0 takes the pin; the top level takes it too, then takes the timer once its select drops.
      ia0_sel = 1'b1;
      top_sel = 1'b1;
      ext_irq = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_a0_reg, 1'b1)
      `CHK(irq_top_level_reg, 1'b1)
      ext_irq = 1'b0;
      top_sel = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK(irq_a0_reg, 1'b0)
      wait_evt(1, n);
      `CHK(n <= 64, 1'b1)
      ia0_sel = 1'b0;
      // Single mode stops, reloads and clears run; a stopped rewrite loads at restart.
      wr(3, 8'hC0);
      wait_evt(0, n);
      repeat (2) @(negedge ref_clk);
      `CHK(timer_control_reg[twu_pkg::CTL_RUN], 1'b0)
      `CHK(count_reg, 16'h0007)
      repeat (40) @(negedge ref_clk);
      `CHK(count_reg, 16'h0007)
      wr(0, 8'h05);
      wr(3, 8'hC0);
      repeat (3) @(negedge ref_clk);
      `CHK(count_reg, 16'h0005)
      // Stop holds the count; restart resumes from it.
      wr(2, 8'h00);
      arm(8'h40, 8'h80);
      repeat (50) @(negedge ref_clk);
      wr(3, 8'h00);
      repeat (2) @(negedge ref_clk);
      held = count_reg;
      `CHK(held < 16'h0040, 1'b1)
      repeat (30) @(negedge ref_clk);
      `CHK(count_reg, held)
      wr(3, 8'h80);
      repeat (20) @(negedge ref_clk);
      `CHK(count_reg < held, 1'b1)
      // Event mode: the first edge arms, then each falling edge counts once.
      c0 = irq_cnt;
      arm(8'h02, 8'h88);
      u_twu_pin_partner.fall();
      `CHK(count_reg, 16'h0002)
      u_twu_pin_partner.fall();
      `CHK(count_reg, 16'h0001)
      u_twu_pin_partner.fall();
      `CHK(irq_cnt, c0)
      u_twu_pin_partner.fall();
      `CHK(irq_cnt, c0 + 1)
      // Gated mode counts only while the pin is high.
      u_twu_pin_partner.level(1'b0);
      arm(8'h40, 8'h98);
      repeat (3) @(negedge ref_clk);
      held = count_reg;
      repeat (40) @(negedge ref_clk);
      `CHK(count_reg, held)
      u_twu_pin_partner.level(1'b1);
      repeat (40) @(negedge ref_clk);
      `CHK(count_reg < held, 1'b1)
      // Triggerable mode waits for a falling edge after run.
      arm(8'h40, 8'hA8);
      repeat (40) @(negedge ref_clk);
      `CHK(count_reg, 16'h0040)
      u_twu_pin_partner.fall();
      repeat (10) @(negedge ref_clk);
      `CHK(count_reg < 16'h0040, 1'b1)
      // Retriggerable mode restarts on an edge while running, ignores it while stopped.
      arm(8'h40, 8'hB8);
      repeat (60) @(negedge ref_clk);
      `CHK(count_reg < 16'h0034, 1'b1)
      u_twu_pin_partner.fall();
      `CHK(count_reg > 16'h003C, 1'b1)
      wr(3, 8'h38);
      held = count_reg;
      u_twu_pin_partner.fall();
      `CHK(count_reg, held)
      // Software watchdog: constant 10h, prescaler 0, run bit left clear.
      do_reset(1'b1);
      wr(0, 8'h10);
      wr(1, 8'h00);
      wr(2, 8'h00);
      wd_bit = 1'b0;
      wr(4, 8'h00);
      `CHK(watchdog_active_reg, 1'b1)
      c0 = rst_cnt;
      repeat (5) begin
         repeat (30) @(negedge ref_clk);
         wr(0, twu_pkg::WD_KEY_FIRST);
         wr(0, twu_pkg::WD_KEY_SECOND);
      end
      `CHK(rst_cnt, c0)
      wait_evt(2, n);
      `CHK(n inside {[60:72]}, 1'b1)
      // Hardware watchdog: fixed FFFFh constant, prescaler still writable.
      wd_bit = 1'b1;
      do_reset(1'b0);
      @(negedge ref_clk);
      `CHK(watchdog_active_reg, 1'b1)
      wr(1, 8'h00);
      wr(2, 8'h00);
      repeat (20) @(negedge ref_clk);
      `CHK(count_reg < 16'hFFFF, 1'b1)
      wr(0, twu_pkg::WD_KEY_FIRST);
      wr(0, twu_pkg::WD_KEY_SECOND);
      // Looked at right after the reload edge, before the next divided tick can step it.
      `CHK(count_reg, 16'hFFFF)
      do_reset(1'b1);
      tally_and_finish();
   end
endmodule
`default_nettype wire
